// ===== include/pvs_defs.svh
// constants of the output-voltage setpoint register group
`ifndef PVS_DEFS_SVH
`define PVS_DEFS_SVH

`define PVS_CMD_MODE        8'h20
`define PVS_CMD_SETPOINT    8'h21
`define PVS_CMD_CEILING     8'h24
`define PVS_CMD_SLEW        8'h27

`define PVS_MODE_FIELD      3'h0
`define PVS_MODE_EXP        5'h17
`define PVS_SLEW_EXP        5'h1A

`define PVS_MANT_W          12
`define PVS_SLEW_W          11
`define PVS_SP_RESET        12'h100
`define PVS_CEIL_RESET_FULL 12'h34D
`define PVS_CEIL_RESET_HALF 12'h69A
`define PVS_SLEW_RESET      11'h03C
`define PVS_SP_INVALID      16'h0B00

`define PVS_BKT_T0          11'h005
`define PVS_BKT_T1          11'h007
`define PVS_BKT_T2          11'h00C
`define PVS_BKT_T3          11'h011
`define PVS_BKT_T4          11'h019
`define PVS_BKT_T5          11'h02F
`define PVS_BKT_T6          11'h04F
`define PVS_BKT_N           7

`endif

// ===== include/pvs_pkg.sv
// types of the output-voltage setpoint register group
package pvs_pkg;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } pvs_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [15:0] data;
   } pvs_rsp_t;

   typedef struct packed {
      logic cml;
      logic ivd;
      logic invalid_command_fault;
      logic other_condition_flag;
      logic output_voltage_warning_flag;
      logic vout_max_min_warn;
      logic smbalert;
   } pvs_event_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] setpoint;
   } pvs_nvm_t;

   typedef enum logic [1:0] {
      PVS_RAMP_NORMAL   = 2'b00,
      PVS_RAMP_TOFF     = 2'b01,
      PVS_RAMP_SOFT_ON  = 2'b10,
      PVS_RAMP_SOFT_OFF = 2'b11
   } pvs_ramp_state_t;

   typedef enum logic [1:0] {
      PVS_SRC_TRANSITION = 2'b00,
      PVS_SRC_SOFT_START = 2'b01,
      PVS_SRC_SOFT_STOP  = 2'b10
   } pvs_ramp_src_t;

endpackage

// ===== logic/pvs_slew_bucket.sv
// maps the slew mantissa onto one of eight fixed transition rates
`timescale 1ns/1ns
`include "pvs_defs.svh"
module pvs_slew_bucket import pvs_pkg::*; (
   // mantissa in
   input  wire logic [10:0] mantissa,
   // bucket out, 0 = slowest
   output logic      [2:0]  bucket
);

   localparam logic [10:0] THR [`PVS_BKT_N] = '{`PVS_BKT_T0, `PVS_BKT_T1, `PVS_BKT_T2,
      `PVS_BKT_T3, `PVS_BKT_T4, `PVS_BKT_T5, `PVS_BKT_T6};

   logic [`PVS_BKT_N-1:0] above;

   genvar i;
   generate
      for (i = 0; i < `PVS_BKT_N; i++) begin : g_thr
         // negative mantissa falls in the slowest bucket
         assign above[i] = $signed(mantissa) > $signed(THR[i]); // R17 R20
      end
   endgenerate

   always_comb begin
      bucket = 3'h0;
      for (int k = 0; k < `PVS_BKT_N; k++) begin
         bucket = bucket + {2'h0, above[k]};
      end
   end

endmodule

// ===== logic/pvs_regs.sv
// output-voltage setpoint register group with reference computation
// Behaviour
// R1 - format descriptor reads mode in bits 7:5, exponent in bits 4:0.
// R2 - mode fixed 000 linear, exponent fixed 10111; writes never change them.
// R3 - loop slave: four registers unchanged, access NACKed, invalid command, alert.
// R4 - reference = setpoint*ratio + trim + enabled margin steps, 2^-9 V counts.
// R5 - host keeps setpoint 179..845 at ratio 1, 358..1024 at ratio 0.5.
// R6 - setpoint write above 2816 NACKed, old value kept, cml and ivd set.
// R7 - setpoint outside min/max window is replaced by the violated limit.
// R8 - setpoint resets to 256; bits 15:12 read zero; bits 11:0 writable.
// R9 - store-default command copies setpoint into nonvolatile storage.
// R10 - ceiling bounds equivalent setpoint after any contributing change; code clamps only the reference word, only while output on.
// R11 - largest reference is ceiling times scale ratio; code lets the reference exceed it while output off.
// R12 - output on: clamp to ceiling on overshoot or crossed limits, ceiling wins.
// R13 - on limit violation raise other, voltage warning, max/min warning, alert.
// R14 - ratio 1: ceiling defaults 845, host keeps it 282..845.
// R15 - ratio 0.5: ceiling defaults 1690, host keeps it 564..1690.
// R16 - transition slope for normal and turn-off wait; soft ramps use own rates.
// R17 - slew value maps into one of eight fixed-rate buckets.
// R18 - slew register: exponent 15:11 read-only, mantissa 10:0 writable.
// R19 - slew exponent fixed 11010, mantissa defaults to 60.
// R20 - bucket thresholds 5, 7, 12, 17, 25, 47, 79 on the mantissa.
// R21 - 16-bit registers moved as words low byte first, descriptor as a byte.
`timescale 1ns/1ns
`include "pvs_defs.svh"
module pvs_regs import pvs_pkg::*; (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // decoded bus command and its answer
   input  wire pvs_cmd_t               cmd_in,
   output logic                        cmd_hit,
   output pvs_rsp_t                    rsp_out,
   // configuration from the rest of the device
   input  wire logic                   loop_slave_pin,
   input  wire logic                   scale_half,
   input  wire logic [11:0]            vout_min_word,
   input  wire logic signed [15:0]     trim_offset,
   input  wire logic signed [15:0]     upper_margin_step,
   input  wire logic signed [15:0]     lower_margin_step,
   input  wire logic                   margin_high_en,
   input  wire logic                   margin_low_en,
   input  wire logic                   output_on,
   input  wire logic                   store_default_all,
   input  wire pvs_ramp_state_t        ramp_state,
   // reference and ramp control
   output logic [15:0]                 error_amp_reference_word,
   output logic signed [17:0]          equivalent_output_setpoint,
   output logic                        ref_clamped,
   output logic [2:0]                  slew_bucket,
   output pvs_ramp_src_t               ramp_src,
   // nonvolatile store and status events
   output pvs_nvm_t                    nvm_store,
   output pvs_event_t                  events
);

   // applies the scale-loop ratio; 0.5 is a right shift
   function automatic logic signed [17:0] pvs_scale(input logic [11:0] v, input logic half);
      logic [11:0] s;
      s = half ? {1'b0, v[11:1]} : v;
      return $signed({6'h00, s});
   endfunction

   function automatic logic pvs_is_own(input logic [7:0] c);
      return (c == `PVS_CMD_MODE) || (c == `PVS_CMD_SETPOINT) ||
             (c == `PVS_CMD_CEILING) || (c == `PVS_CMD_SLEW);
   endfunction

   // loop-slave strap synchroniser
   logic [2:0]  sync_reg;
   logic [2:0]  sync_next;
   logic        slave_reg;
   logic        slave_next;

   // register contents
   logic [11:0] setpoint_reg;
   logic [11:0] setpoint_next;
   logic [11:0] ceiling_reg;
   logic [11:0] ceiling_next;
   logic [10:0] slew_reg;
   logic [10:0] slew_next;
   logic        init_reg;
   logic        init_next;

   // outputs and status
   pvs_rsp_t          rsp_reg;
   pvs_rsp_t          rsp_next;
   pvs_event_t        ev_reg;
   pvs_event_t        ev_next;
   pvs_nvm_t          nvm_reg;
   pvs_nvm_t          nvm_next;
   logic [15:0]       ref_reg;
   logic [15:0]       ref_next;
   logic signed [17:0] equiv_reg;
   logic signed [17:0] equiv_next;
   logic              clamp_reg;
   logic              clamp_next;
   logic              viol_reg;
   logic              viol_next;
   pvs_ramp_src_t     src_reg;
   pvs_ramp_src_t     src_next;

   logic [11:0]        sp_eff;
   logic signed [17:0] max_ref;
   logic signed [17:0] min_ref;
   logic signed [17:0] sum;
   logic               limit_wr;

   always_comb begin
      sync_next  = {sync_reg[1:0], loop_slave_pin};
      slave_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : slave_reg;
   end

   // reference path, recomputed every cycle so any input change is bounded while output_on is high
   always_comb begin
      if (ceiling_reg <= vout_min_word) begin
         sp_eff = ceiling_reg; // R7
      end else if (setpoint_reg > ceiling_reg) begin
         sp_eff = ceiling_reg; // R7
      end else if (setpoint_reg < vout_min_word) begin
         sp_eff = vout_min_word; // R7
      end else begin
         sp_eff = setpoint_reg;
      end
      max_ref = pvs_scale(ceiling_reg, scale_half); // R11
      min_ref = pvs_scale(vout_min_word, scale_half);
      sum = pvs_scale(sp_eff, scale_half) + 18'(trim_offset); // R4
      if (margin_high_en) begin
         sum = sum + 18'(upper_margin_step); // R4
      end
      if (margin_low_en) begin
         sum = sum + 18'(lower_margin_step); // R4
      end
      equiv_next = sum;
      viol_next  = output_on && ((sum > max_ref) || (ceiling_reg <= vout_min_word) ||
                   (sum < min_ref)); // R10 R12
      clamp_next = viol_next;
      if (output_on && ((sum > max_ref) || (ceiling_reg <= vout_min_word))) begin
         ref_next = max_ref[15:0]; // R12
      end else if (output_on && (sum < min_ref)) begin
         ref_next = min_ref[15:0];
      end else if (sum < 18'sd0) begin
         ref_next = 16'h0000;
      end else begin
         ref_next = sum[15:0];
      end
   end

   // command handling
   always_comb begin
      setpoint_next = setpoint_reg;
      ceiling_next  = ceiling_reg;
      slew_next     = slew_reg;
      init_next     = 1'b1;
      rsp_next      = '0;
      ev_next       = '0;
      limit_wr      = 1'b0;
      cmd_hit       = pvs_is_own(cmd_in.code);
      if (!init_reg && scale_half) begin
         ceiling_next = `PVS_CEIL_RESET_HALF; // R15
      end
      if (cmd_in.valid && cmd_hit) begin
         rsp_next.valid = 1'b1;
         rsp_next.ack   = 1'b1;
         if (slave_reg) begin
            rsp_next.ack                  = 1'b0; // R3
            ev_next.invalid_command_fault = 1'b1; // R3
            ev_next.smbalert              = 1'b1; // R3
         end else if (cmd_in.write) begin
            if (cmd_in.code == `PVS_CMD_SETPOINT) begin
               if (cmd_in.data > `PVS_SP_INVALID) begin
                  rsp_next.ack = 1'b0; // R6
                  ev_next.cml  = 1'b1; // R6
                  ev_next.ivd  = 1'b1; // R6
               end else begin
                  setpoint_next = cmd_in.data[11:0]; // R8
                  limit_wr      = 1'b1;
               end
            end else if (cmd_in.code == `PVS_CMD_CEILING) begin
               ceiling_next = cmd_in.data[11:0];
               limit_wr     = 1'b1;
            end else if (cmd_in.code == `PVS_CMD_SLEW) begin
               slew_next = cmd_in.data[10:0]; // R18
            end
            // descriptor writes are accepted and have no effect
         end else begin
            if (cmd_in.code == `PVS_CMD_MODE) begin
               rsp_next.data = {8'h00, `PVS_MODE_FIELD, `PVS_MODE_EXP}; // R1 R2 R21
            end else if (cmd_in.code == `PVS_CMD_SETPOINT) begin
               rsp_next.data = {4'h0, setpoint_reg}; // R8 R21
            end else if (cmd_in.code == `PVS_CMD_CEILING) begin
               rsp_next.data = {4'h0, ceiling_reg}; // R21
            end else begin
               rsp_next.data = {`PVS_SLEW_EXP, slew_reg}; // R18 R19
            end
         end
      end
      if (viol_next && (!viol_reg || limit_wr)) begin
         ev_next.other_condition_flag        = 1'b1; // R13
         ev_next.output_voltage_warning_flag = 1'b1; // R13
         ev_next.vout_max_min_warn           = 1'b1; // R13
         ev_next.smbalert                    = 1'b1; // R13
      end
      nvm_next.valid    = store_default_all; // R9
      nvm_next.setpoint = store_default_all ? setpoint_reg : nvm_reg.setpoint; // R9
      if (ramp_state == PVS_RAMP_SOFT_ON) begin
         src_next = PVS_SRC_SOFT_START; // R16
      end else if (ramp_state == PVS_RAMP_SOFT_OFF) begin
         src_next = PVS_SRC_SOFT_STOP; // R16
      end else begin
         src_next = PVS_SRC_TRANSITION; // R16
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg     <= 3'h0;
         slave_reg    <= 1'b0;
         setpoint_reg <= `PVS_SP_RESET; // R8
         ceiling_reg  <= `PVS_CEIL_RESET_FULL; // R14
         slew_reg     <= `PVS_SLEW_RESET; // R19
         init_reg     <= 1'b0;
         rsp_reg      <= '0;
         ev_reg       <= '0;
         nvm_reg      <= '0;
         ref_reg      <= 16'h0000;
         equiv_reg    <= 18'sd0;
         clamp_reg    <= 1'b0;
         viol_reg     <= 1'b0;
         src_reg      <= PVS_SRC_TRANSITION;
      end else begin
         sync_reg     <= sync_next;
         slave_reg    <= slave_next;
         setpoint_reg <= setpoint_next;
         ceiling_reg  <= ceiling_next;
         slew_reg     <= slew_next;
         init_reg     <= init_next;
         rsp_reg      <= rsp_next;
         ev_reg       <= ev_next;
         nvm_reg      <= nvm_next;
         ref_reg      <= ref_next;
         equiv_reg    <= equiv_next;
         clamp_reg    <= clamp_next;
         viol_reg     <= viol_next;
         src_reg      <= src_next;
      end
   end

   pvs_slew_bucket u_bucket (
      .mantissa (slew_reg),
      .bucket   (slew_bucket)
   );

   assign rsp_out                    = rsp_reg;
   assign events                     = ev_reg;
   assign nvm_store                  = nvm_reg;
   assign error_amp_reference_word   = ref_reg;
   assign equivalent_output_setpoint = equiv_reg;
   assign ref_clamped                = clamp_reg;
   assign ramp_src                   = src_reg;

endmodule

// ===== tb/pvs_regs_monitor.sv
// assertion checker for the setpoint register group
`timescale 1ns/1ns
module pvs_regs_monitor import pvs_pkg::*; (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // command side
   input wire pvs_cmd_t   cmd_in,
   input wire logic       cmd_hit,
   input wire logic       output_on,
   // answers and status
   input wire pvs_rsp_t   rsp_out,
   input wire pvs_event_t events,
   input wire logic       ref_clamped
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(c); cmd_in.valid && !cmd_in.write && cmd_in.code == c; endsequence
   sequence s_ok; rsp_out.valid && rsp_out.ack; endsequence
   property p_mode; s_rd(8'h20) ##1 s_ok |-> rsp_out.data == 16'h0017; endproperty
   a_mode: assert property (p_mode) else $error("mode byte wrong");
   property p_sp_hi; s_rd(8'h21) ##1 s_ok |-> rsp_out.data[15:12] == 4'h0; endproperty
   a_sp_hi: assert property (p_sp_hi) else $error("setpoint top bits set");
   property p_slew; s_rd(8'h27) ##1 s_ok |-> rsp_out.data[15:11] == 5'h1A; endproperty
   a_slew: assert property (p_slew) else $error("slew exponent wrong");
   property p_bad_sp;
      cmd_in.valid && cmd_in.write && cmd_in.code == 8'h21 && cmd_in.data > 16'h0B00
      |=> !rsp_out.ack && (events.ivd || events.invalid_command_fault);
   endproperty
   a_bad_sp: assert property (p_bad_sp) else $error("bad setpoint acked");
   property p_rsp_time; 1'b1 |=> rsp_out.valid == $past(cmd_in.valid && cmd_hit); endproperty
   a_rsp_time: assert property (p_rsp_time) else $error("answer timing wrong");
   property p_nack;
      rsp_out.valid && !rsp_out.ack && !events.ivd
      |-> events.invalid_command_fault && events.smbalert;
   endproperty
   a_nack: assert property (p_nack) else $error("refusal without fault");
   property p_clamp_on; ref_clamped |-> $past(output_on); endproperty
   a_clamp_on: assert property (p_clamp_on) else $error("clamp while off");
   property p_warn;
      $rose(ref_clamped) |-> events.other_condition_flag && events.vout_max_min_warn
         && events.output_voltage_warning_flag && events.smbalert;
   endproperty
   a_warn: assert property (p_warn) else $error("clamp without warning");
endmodule
bind pvs_regs pvs_regs_monitor u_pvs_regs_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
   .cmd_in(cmd_in), .cmd_hit(cmd_hit), .output_on(output_on), .rsp_out(rsp_out),
   .events(events), .ref_clamped(ref_clamped));

// ===== tb/pvs_host.sv
// host model issuing register commands on the decoded bus
`timescale 1ns/1ns
module pvs_host import pvs_pkg::*; (
   // clock
   input wire logic     sys_clk,
   // command out, answer in
   output pvs_cmd_t     cmd,
   input wire pvs_rsp_t rsp
);
   initial cmd = '0;
   // words arrive already paired low byte first; data scrambled once released
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic ok, output logic ack, output logic [15:0] q);
      int n;
      @(posedge sys_clk);
      cmd <= '{1'b1, w, c, d};
      @(posedge sys_clk);
      cmd <= '{1'b0, 1'b0, ~c, ~d};
      n = 0;
      #1;
      while (rsp.valid !== 1'b1 && n < 3) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      ok = (rsp.valid === 1'b1);
      ack = rsp.ack;
      q = rsp.data;
   endtask
endmodule

// ===== tb/pvs_regs_test.sv
// self-checking bench of the setpoint register group
`timescale 1ns/1ns
module pvs_regs_test import pvs_pkg::*; ;
   logic               sys_clk = 0, rst_n = 0, half = 0, slave = 0, on = 0, store = 0;
   logic               men_h = 0, men_l = 0, ok, ack, hit, clamp;
   logic signed [15:0] trim = 0, mh = 0, ml = 0;
   logic        [15:0] q, ref_w;
   logic        [11:0] sp = 12'h100, vmin = 12'h0B3;
   logic        [2:0]  bkt;
   logic signed [17:0] eq;
   logic        [10:0] mt[10] = '{5, 6, 7, 12, 13, 25, 26, 79, 80, 11'h7FF};
   pvs_ramp_state_t    rs = PVS_RAMP_NORMAL;
   pvs_ramp_src_t      src;
   pvs_cmd_t           cmd;
   pvs_rsp_t           rsp;
   pvs_nvm_t           nvm;
   pvs_event_t         ev;
   int                 err_total = 0, comparisons = 0, seed = 32'hedabb2a5;
   always #5 sys_clk = ~sys_clk;
   pvs_host u_pvs_host (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp));
   pvs_regs u_pvs_regs (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_in(cmd), .cmd_hit(hit),
      .rsp_out(rsp), .loop_slave_pin(slave), .scale_half(half), .vout_min_word(vmin),
      .trim_offset(trim), .upper_margin_step(mh), .lower_margin_step(ml),
      .margin_high_en(men_h), .margin_low_en(men_l), .output_on(on),
      .store_default_all(store), .ramp_state(rs), .error_amp_reference_word(ref_w),
      .equivalent_output_setpoint(eq), .ref_clamped(clamp), .slew_bucket(bkt),
      .ramp_src(src), .nvm_store(nvm), .events(ev));
   task results;
      if (err_total == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [7:0] c, input logic [15:0] d);
      u_pvs_host.xfer(w, c, d, ok, ack, q);
      chk(ok, 1);
      if (ok !== 1'b1) results;
   endtask
   task rd(input logic [7:0] c, input logic [15:0] exp);
      acc(1'b0, c, 16'h0000);
      chk(ack, 1);
      chk(q, exp);
   endtask
   task rst(input logic h);
      rst_n <= 1'b0;
      half <= h;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask
   function automatic logic [2:0] bkt_of(input logic [10:0] m);
      int t[7] = '{5, 7, 12, 17, 25, 47, 79};
      bkt_of = 3'h7;
      for (int k = 6; k >= 0; k--) if (m <= t[k]) bkt_of = 3'(k);
      if (m[10]) bkt_of = 3'h0;
   endfunction
   function automatic int sum_of();
      int s;
      s = int'(half ? sp >> 1 : sp) + int'(trim) + (men_h ? int'(mh) : 0);
      return s + (men_l ? int'(ml) : 0);
   endfunction
   function automatic logic [15:0] ref_of();
      return (sum_of() < 0) ? 16'h0000 : 16'(sum_of());
   endfunction
   task rnd(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge sys_clk);
         trim <= 16'($random(seed) % 32);
         mh <= 16'($random(seed) % 32);
         ml <= 16'($random(seed) % 32);
         {men_h, men_l} <= 2'($random(seed));
         sp = (half ? 12'd358 : 12'd179) + 12'($unsigned($random(seed)) % 667);
         acc(1'b1, 8'h21, {4'h0, sp});
         chk(ack, 1);
         repeat (2) @(posedge sys_clk);
         #1;
         chk(ref_w, ref_of());
         chk(eq, sum_of());
         chk(clamp, 0);
      end
   endtask
   initial begin
      rst(1'b0);
      rd(8'h20, 16'h0017);
      rd(8'h21, 16'h0100);
      rd(8'h24, 16'h034D);
      rd(8'h27, 16'hD03C);
      u_pvs_host.xfer(1'b0, 8'hDE, 16'h0000, ok, ack, q);
      chk({ok, hit}, 2'b01);
      acc(1'b1, 8'h20, 16'hFFFF);
      rd(8'h20, 16'h0017);
      acc(1'b1, 8'h21, 16'h0B01);
      chk({ack, ev.cml, ev.ivd}, 3'b011);
      rd(8'h21, 16'h0100);
      for (int k = 0; k < 10; k++) begin
         acc(1'b1, 8'h27, {5'h00, mt[k]});
         rd(8'h27, {5'h1A, mt[k]});
         chk(bkt, bkt_of(mt[k]));
      end
      rnd(12);
      sp = 12'd845;
      acc(1'b1, 8'h21, 16'h034D);
      chk(ack, 1);
      @(posedge sys_clk);
      {on, men_h, men_l, trim} <= {3'b100, 16'sd40};
      @(posedge sys_clk);
      #1;
      chk({clamp, ref_w}, {1'b1, 16'h034D});
      chk({ev.other_condition_flag, ev.smbalert}, 2'h3);
      chk({ev.output_voltage_warning_flag, ev.vout_max_min_warn}, 2'h3);
      chk(eq, 32'h00000375);
      @(posedge sys_clk);
      on <= 1'b0;
      store <= 1'b1;
      @(posedge sys_clk);
      store <= 1'b0;
      #1;
      chk({nvm.valid, nvm.setpoint}, {1'b1, sp});
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         rs <= pvs_ramp_state_t'(k);
         @(posedge sys_clk);
         #1;
         chk(src, (k < 2) ? 0 : k - 1);
      end
      @(posedge sys_clk);
      slave <= 1'b1;
      repeat (5) @(posedge sys_clk);
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, 8'(k == 0 ? 8'h20 : 8'h21 + 3 * (k - 1)), 16'h0123);
         chk({ack, ev.invalid_command_fault, ev.smbalert}, 3'b011);
         acc(1'b0, 8'(k == 0 ? 8'h20 : 8'h21 + 3 * (k - 1)), 16'h0000);
         chk(ack, 0);
      end
      @(posedge sys_clk);
      slave <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rd(8'h21, {4'h0, sp});
      // setpoint below the lower limit, then lower limit at the ceiling
      @(posedge sys_clk);
      vmin <= 12'h200;
      acc(1'b1, 8'h21, 16'h00C0);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(ref_w, 16'h0228);
      @(posedge sys_clk);
      vmin <= 12'h34D;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(ref_w, 16'h0375);
      @(posedge sys_clk);
      vmin <= 12'h0B3;
      rst(1'b1);
      rd(8'h24, 16'h069A);
      rnd(12);
      results;
   end
endmodule
